// ---- logic/acrc_consts.svh ----
// Constants of the calibration and reset control block.
// Assumes inclusion by bare name from the design file only.
`ifndef ACRC_CONSTS_SVH
`define ACRC_CONSTS_SVH
// Register byte offsets
`define ACRC_CFG_OFS     8'h00
`define ACRC_MODE_OFS    8'h04
`define ACRC_STAT_OFS    8'h08
`define ACRC_DATA_OFS    8'h0C
`define ACRC_OFF_OFS     8'h10
`define ACRC_FS_OFS      8'h20
// Configuration field positions
`define ACRC_GAIN_POS    0
`define ACRC_CHOP_POS    3
`define ACRC_REFERENCE_SELECT_POS  4
`define ACRC_CHAN_POS    8
// Status field positions
`define ACRC_RDYN_POS    0
`define ACRC_BUSY_POS    1
`define ACRC_SETL_POS    2
// Reset values
`define ACRC_FS_RST      24'h800000
`define ACRC_OFF_RST     24'h000000
`define ACRC_CHOP_RST    1'b1
// Supply monitor channel code
`define ACRC_MON_CHAN    3'h7
// Serial reset word length
`define ACRC_RST_ONES    6'd32
// Settling time after reset
`define ACRC_RST_WAIT_US 500
`define ACRC_CLK_MHZ     50
// Calibration lengths in conversion cycles
`define ACRC_ZS_LEN      3'd2
`define ACRC_IFS1C_LEN   3'd2
`define ACRC_IFS1_LEN    3'd1
`define ACRC_IFSHC_LEN   3'd4
`define ACRC_IFSH_LEN    3'd2
`define ACRC_SFS_LEN     3'd2
// Full-scale coefficient binary point
`define ACRC_FS_SHIFT    23
`endif

// ---- logic/acrc_pkg.sv ----
// Types of the calibration and reset control block.
// Assumes nothing beyond the constants header.
`default_nettype none
package acrc_pkg;
  // Operating mode field codes
  typedef enum logic [2:0] {
    MD_CONT   = 3'h0,
    MD_SINGLE = 3'h1,
    MD_IDLE   = 3'h2,
    MD_PDOWN  = 3'h3,
    MD_IZS    = 3'h4,
    MD_IFS    = 3'h5,
    MD_SZS    = 3'h6,
    MD_SFS    = 3'h7
  } acrc_mode_e;
  // Calibration sequencer states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_CAL  = 2'b10
  } acrc_cal_e;
  // Whole state of the block
  typedef struct packed {
    logic [2:0]        sclk_sy;
    logic [2:0]        din_sy;
    logic [2:0]        csn_sy;
    logic              sclk_st;
    logic              din_st;
    logic              csn_st;
    logic [5:0]        ones_cnt;
    logic              soft_rst;
    logic [2:0]        gain;
    logic              chop;
    logic              reference_select;
    logic [2:0]        chan;
    acrc_mode_e        mode;
    acrc_cal_e         cst;
    logic [2:0]        cal_cnt;
    logic              rdy_n;
    logic [23:0]       data;
    logic [3:0][23:0]  off;
    logic [3:0][23:0]  fs;
    logic [15:0]       settle;
    logic              a_sel;
    logic              a_wr;
    logic [7:0]        a_addr;
    logic [31:0]       rdata;
  } acrc_state_s;
endpackage
`default_nettype wire

// ---- logic/acrc_top.sv ----
// Calibration sequencing, serial reset and reference control.
// Assumes an AHB-Lite master, a modulator that pulses raw_valid_i
// once per conversion, and serial pins from the host's own clock.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "acrc_consts.svh"
module acrc_top
  import acrc_pkg::*;
#(
  parameter int RST_WAIT_CYC = `ACRC_RST_WAIT_US * `ACRC_CLK_MHZ
)(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        sclk_i,
  input  wire logic        din_i,
  input  wire logic        cs_n_i,
  output logic             dout_rdy_n_o,
  output logic             dout_oe_n_o,
  input  wire logic        raw_valid_i,
  input  wire logic [23:0] raw_data_i,
  output logic             ref_internal_o,
  output logic             ext_ref_connect_o,
  output logic             supply_monitor_o,
  output logic [2:0]       ain_select_o,
  output logic [2:0]       gain_select_o,
  output logic             int_zero_mux_o,
  output logic             int_full_mux_o,
  output logic             filter_reset_o
);
  // Reset value of the whole state
  localparam acrc_state_s RST_S = '{
    mode:    MD_CONT,
    cst:     CS_IDLE,
    rdy_n:   1'b1,
    chop:    `ACRC_CHOP_RST,
    off:     {4{`ACRC_OFF_RST}},
    fs:      {4{`ACRC_FS_RST}},
    settle:  16'(RST_WAIT_CYC),
    sclk_sy: 3'h7, sclk_st: 1'b1, // Clock idles high, no false edge
    csn_sy:  3'h7, csn_st:  1'b1, // Deselected, ready pin not driven
    default: '0
  };
  logic [1:0]         rst_sy_ff;  // Reset release synchroniser
  logic               rst_n;      // Synchronised reset
  acrc_state_s        s_ff;       // Registered state
  acrc_state_s        nxt_s;      // Next state
  logic               rise_w;     // Serial clock rising edge
  logic               ahb_go_w;   // Address phase accepted
  logic               wr_mode_w;  // Mode register written
  logic               cal_end_w;  // Last calibration conversion
  logic [1:0]         idx_w;      // Coefficient slot of channel
  logic signed [24:0] diff_w;     // Offset-removed result
  logic signed [49:0] prod_w;     // Scaled product
  logic signed [49:0] scl_w;      // Product at binary point
  logic [23:0]        corr_w;     // Clamped corrected result
  logic [2:0]         len_w;      // Calibration length
  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sy_ff <= 2'b00;
    else
      rst_sy_ff <= {rst_sy_ff[0], 1'b1};
  end
  assign rst_n = rst_sy_ff[1];
  // Supply monitor slot sits after the three inputs
  assign idx_w = (s_ff.chan == `ACRC_MON_CHAN) ? 2'd3 :
                 (s_ff.chan[1:0] == 2'd3) ? 2'd2 : s_ff.chan[1:0];
  // Correction: offset first, then full-scale factor
  always_comb
  begin
    diff_w = $signed({1'b0, raw_data_i}) - $signed({1'b0, s_ff.off[idx_w]});
    prod_w = 50'(diff_w) * $signed({26'h0, s_ff.fs[idx_w]});
    scl_w  = prod_w >>> `ACRC_FS_SHIFT;
    if (scl_w < 0)
      corr_w = 24'h000000;
    else if (scl_w > 50'sh0FFFFFF)
      corr_w = 24'hFFFFFF;
    else
      corr_w = scl_w[23:0];
  end
  // Calibration length from mode, gain and chopping
  always_comb
  begin
    case (hwdata_i[2:0])
      MD_IZS, MD_SZS:
        len_w = `ACRC_ZS_LEN;
      MD_IFS:
        if (s_ff.gain == 3'h0)
          len_w = s_ff.chop ? `ACRC_IFS1C_LEN : `ACRC_IFS1_LEN;
        else
          len_w = s_ff.chop ? `ACRC_IFSHC_LEN : `ACRC_IFSH_LEN;
      MD_SFS:
        len_w = `ACRC_SFS_LEN;
      default:
        len_w = 3'd0;
    endcase
  end
  // Only whole-word transfers are taken
  assign ahb_go_w  = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);
  assign wr_mode_w = s_ff.a_sel && s_ff.a_wr && (s_ff.a_addr == `ACRC_MODE_OFS);
  assign rise_w    = !s_ff.sclk_st && (s_ff.sclk_sy[1] == s_ff.sclk_sy[2])
                     && s_ff.sclk_sy[2];
  assign cal_end_w = (s_ff.cst == CS_CAL) && raw_valid_i && (s_ff.cal_cnt == 3'd1);
  // Next-state logic
  always_comb
  begin
    nxt_s = s_ff;
    // Pin synchronisers, three flops each
    nxt_s.sclk_sy = {s_ff.sclk_sy[1:0], sclk_i};
    nxt_s.din_sy  = {s_ff.din_sy[1:0], din_i};
    nxt_s.csn_sy  = {s_ff.csn_sy[1:0], cs_n_i};
    // Accept a level once second and third agree
    if (s_ff.sclk_sy[1] == s_ff.sclk_sy[2])
      nxt_s.sclk_st = s_ff.sclk_sy[2];
    if (s_ff.din_sy[1] == s_ff.din_sy[2])
      nxt_s.din_st = s_ff.din_sy[2];
    if (s_ff.csn_sy[1] == s_ff.csn_sy[2])
      nxt_s.csn_st = s_ff.csn_sy[2];
    nxt_s.soft_rst = 1'b0;
    // Settling countdown after any reset
    if (s_ff.settle != 16'h0000)
      nxt_s.settle = s_ff.settle - 16'h0001;
    // Address phase capture
    nxt_s.a_sel  = ahb_go_w;
    nxt_s.a_wr   = hwrite_i;
    nxt_s.a_addr = haddr_i[7:0];
    // Reading data releases the ready flag
    if (ahb_go_w && !hwrite_i && haddr_i[7:0] == `ACRC_DATA_OFS)
      nxt_s.rdy_n = 1'b1;
    // Register writes in the data phase
    if (s_ff.a_sel && s_ff.a_wr)
    begin
      case (s_ff.a_addr)
        `ACRC_CFG_OFS:
        begin
          nxt_s.gain   = hwdata_i[`ACRC_GAIN_POS +: 3];
          nxt_s.chop   = hwdata_i[`ACRC_CHOP_POS];
          nxt_s.reference_select = hwdata_i[`ACRC_REFERENCE_SELECT_POS];
          nxt_s.chan   = hwdata_i[`ACRC_CHAN_POS +: 3];
        end
        `ACRC_MODE_OFS:
        begin
          nxt_s.mode = acrc_mode_e'(hwdata_i[2:0]);
          if (hwdata_i[2])
          begin
            // Calibration code starts the sequencer
            nxt_s.cst     = CS_CAL;
            nxt_s.cal_cnt = len_w;
            nxt_s.rdy_n   = 1'b1;
          end
          else
            nxt_s.cst = CS_IDLE;
        end
        default:
        begin
          // Coefficients writable; others ignored
          if (s_ff.a_addr[7:4] == 4'h1)
            nxt_s.off[s_ff.a_addr[3:2]] = hwdata_i[23:0];
          else if (s_ff.a_addr[7:4] == 4'h2)
            nxt_s.fs[s_ff.a_addr[3:2]] = hwdata_i[23:0];
        end
      endcase
    end
    // Calibration sequencing
    case (s_ff.cst)
      CS_CAL:
      begin
        if (cal_end_w && !wr_mode_w)
        begin
          // Store coefficient, flag ready, go idle
          if (s_ff.mode == MD_IZS || s_ff.mode == MD_SZS)
            nxt_s.off[idx_w] = raw_data_i;
          else
            nxt_s.fs[idx_w] = raw_data_i;
          nxt_s.rdy_n = 1'b0;
          nxt_s.mode  = MD_IDLE;
          nxt_s.cst   = CS_IDLE;
        end
        else if (raw_valid_i && !wr_mode_w)
          nxt_s.cal_cnt = s_ff.cal_cnt - 3'd1;
      end
      CS_IDLE:
      begin
        // Normal conversion, set wins over read
        if (raw_valid_i && !wr_mode_w &&
            (s_ff.mode == MD_CONT || s_ff.mode == MD_SINGLE))
        begin
          nxt_s.data  = corr_w;
          nxt_s.rdy_n = 1'b0;
          if (s_ff.mode == MD_SINGLE)
            nxt_s.mode = MD_IDLE;
        end
      end
      default:
        nxt_s.cst = CS_IDLE;
    endcase
    // Serial reset word detector
    if (rise_w && !s_ff.csn_st)
    begin
      if (!nxt_s.din_st)
        nxt_s.ones_cnt = 6'd0;
      else if (s_ff.ones_cnt == `ACRC_RST_ONES - 6'd1)
      begin
        // Full reset, synchronisers kept
        nxt_s          = RST_S;
        nxt_s.sclk_sy  = {s_ff.sclk_sy[1:0], sclk_i};
        nxt_s.din_sy   = {s_ff.din_sy[1:0], din_i};
        nxt_s.csn_sy   = {s_ff.csn_sy[1:0], cs_n_i};
        nxt_s.din_st   = 1'b1;
        nxt_s.csn_st   = s_ff.csn_st;
        nxt_s.soft_rst = 1'b1;
      end
      else
        nxt_s.ones_cnt = s_ff.ones_cnt + 6'd1;
    end
    // Read data from the updated state
    nxt_s.rdata = 32'h00000000;
    if (ahb_go_w && !hwrite_i)
    begin
      case (haddr_i[7:0])
        `ACRC_CFG_OFS:
          nxt_s.rdata = {21'h0, nxt_s.chan, 3'h0, nxt_s.reference_select,
                         nxt_s.chop, nxt_s.gain};
        `ACRC_MODE_OFS:
          nxt_s.rdata = {29'h0, nxt_s.mode};
        `ACRC_STAT_OFS:
          nxt_s.rdata = {29'h0, (nxt_s.settle != 16'h0000),
                         (nxt_s.cst == CS_CAL), nxt_s.rdy_n};
        `ACRC_DATA_OFS:
          nxt_s.rdata = {8'h00, nxt_s.data};
        default:
          if (haddr_i[7:4] == 4'h1)
            nxt_s.rdata = {8'h00, nxt_s.off[haddr_i[3:2]]};
          else if (haddr_i[7:4] == 4'h2)
            nxt_s.rdata = {8'h00, nxt_s.fs[haddr_i[3:2]]};
      endcase
    end
  end
  // State register; power-up reset loads RST_S
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= RST_S;
    else
      s_ff <= nxt_s;
  end
  // Bus answers at once, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = s_ff.rdata;
  // Ready pin driven only under chip select
  assign dout_rdy_n_o = s_ff.rdy_n;
  assign dout_oe_n_o  = s_ff.csn_st;
  // Reference and input routing
  assign supply_monitor_o  = (s_ff.chan == `ACRC_MON_CHAN);
  assign ref_internal_o    = s_ff.reference_select || supply_monitor_o;
  assign ext_ref_connect_o = !ref_internal_o;
  assign ain_select_o      = s_ff.chan;
  assign gain_select_o     = s_ff.gain;
  assign int_zero_mux_o    = (s_ff.cst == CS_CAL) && (s_ff.mode == MD_IZS);
  assign int_full_mux_o    = (s_ff.cst == CS_CAL) && (s_ff.mode == MD_IFS);
  assign filter_reset_o    = s_ff.soft_rst;
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);
  ones_reset_a: assert property (
    rise_w && !s_ff.csn_st && s_ff.din_sy[2] && s_ff.ones_cnt == 6'd31
    |=> s_ff.soft_rst && s_ff.mode == MD_CONT && s_ff.ones_cnt == 6'd0)
    else $error("serial reset word not acted on");
  zero_clear_a: assert property (
    rise_w && !s_ff.csn_st && !s_ff.din_sy[2] |=> s_ff.ones_cnt == 6'd0)
    else $error("zero bit did not clear count");
  soft_default_a: assert property (
    s_ff.soft_rst |-> s_ff.fs[0] == `ACRC_FS_RST && s_ff.rdy_n
    && s_ff.cst == CS_IDLE && s_ff.settle != 16'h0000)
    else $error("registers not at defaults after reset");
  mon_ref_a: assert property (supply_monitor_o |-> ref_internal_o && !ext_ref_connect_o)
    else $error("supply channel without internal reference");
  cal_start_a: assert property (
    wr_mode_w && hwdata_i[2] && !s_ff.soft_rst && !(rise_w && s_ff.ones_cnt == 6'd31)
    |=> s_ff.cst == CS_CAL && s_ff.rdy_n)
    else $error("calibration did not start");
  cal_end_a: assert property (
    cal_end_w && !wr_mode_w && !rise_w
    |=> s_ff.cst == CS_IDLE && s_ff.mode == MD_IDLE && !s_ff.rdy_n)
    else $error("calibration did not end correctly");
  ifs_len_a: assert property (
    wr_mode_w && hwdata_i[2:0] == 3'h5 && s_ff.gain != 3'h0 && s_ff.chop && !rise_w
    |=> s_ff.cal_cnt == 3'd4)
    else $error("wrong internal full-scale length");
  zs_len_a: assert property (
    wr_mode_w && hwdata_i[2:0] == 3'h4 && !rise_w |=> s_ff.cal_cnt == 3'd2)
    else $error("wrong offset calibration length");
  fs_store_a: assert property (
    cal_end_w && !wr_mode_w && !rise_w && s_ff.mode == MD_SFS
    |=> s_ff.fs[$past(idx_w)] == $past(raw_data_i))
    else $error("full-scale coefficient not stored");
  corr_a: assert property (
    s_ff.cst == CS_IDLE && s_ff.mode == MD_CONT && raw_valid_i && !wr_mode_w && !rise_w
    |=> s_ff.data == $past(corr_w) && !s_ff.rdy_n)
    else $error("corrected result not stored");
  cal_done_c:  cover property (cal_end_w);
  soft_rst_c:  cover property (s_ff.soft_rst);
  conv_done_c: cover property (s_ff.cst == CS_IDLE && raw_valid_i && s_ff.mode == MD_CONT);
endmodule
`default_nettype wire

// ---- tb/acrc_host_model.sv ----
// Host side of the three-wire serial port, behavioural.
// Assumes the bench calls frame; link clock period is 160 ns.
`timescale 1ns/10ps
`default_nettype none
module acrc_host_model (
  output logic sclk_o,
  output logic din_o,
  output logic cs_n_o
);
  // Idle: clock high and still, not selected
  initial
  begin
    sclk_o = 1'b1;
    din_o  = 1'b0;
    cs_n_o = 1'b1;
  end
  // Shift a run of ones, optionally closed by a zero
  task automatic frame(input int ones, input bit tail0);
    #7; // Keep pin changes off the sampling edge
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < ones + tail0; i++)
    begin
      sclk_o = 1'b0;
      din_o  = (i < ones);
      #80;
      sclk_o = 1'b1;
      #80;
    end
    #80;
    cs_n_o = 1'b1;
    din_o  = ~din_o; // Released line shows no stale level
  endtask
endmodule
`default_nettype wire

// ---- tb/adc_calibration_reset_control_tb.sv ----
// Self-checking bench for the calibration and reset control block.
// Assumes a zero-wait AHB-Lite slave and the serial host model.
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_reset_control_tb;
  localparam int RW = 20;            // Short settling count
  logic        clk = 1'b0;           // 50 MHz clock
  logic        nrst = 1'b0;          // Active-low reset
  logic        hsel = 1'b0;          // Bus select
  logic        hwrite = 1'b0;        // Bus direction
  logic        rv = 1'b0;            // Raw result strobe
  logic [1:0]  htrans = 2'h0;        // Transfer kind
  logic [31:0] haddr = 32'h0;        // Bus address
  logic [31:0] hwdata = 32'h0;       // Bus write data
  logic [23:0] raw = 24'h0;          // Raw result
  wire logic   hro, hresp, rdy_n, oe_n, ref_int, ext_ref, sup_mon, zmux, fmux, frst;
  wire logic   sclk, din, cs_n;
  wire logic [31:0] hrdata;
  wire logic [2:0]  ain, gsel;
  int          bad_count = 0;        // Mismatches
  int          check_count = 0;      // Comparisons
  int          seed = 32'h87f6;      // Fixed seed
  int          nfr = 0;              // Filter reset pulses seen
  int          nsel = 0;             // Cycles with ready pin driven
  // Clock
  always #10 clk = ~clk;
  // Count filter reset pulses and driven-pin cycles
  always @(posedge clk)
  begin
    if (frst === 1'b1)
      nfr++;
    if (oe_n === 1'b0)
      nsel++;
  end
  acrc_top #(.RST_WAIT_CYC(RW)) dut (
    .ref_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hro), .hreadyout_o(hro), .hresp_o(hresp), .hrdata_o(hrdata),
    .sclk_i(sclk), .din_i(din), .cs_n_i(cs_n), .dout_rdy_n_o(rdy_n),
    .dout_oe_n_o(oe_n), .raw_valid_i(rv), .raw_data_i(raw),
    .ref_internal_o(ref_int), .ext_ref_connect_o(ext_ref),
    .supply_monitor_o(sup_mon), .ain_select_o(ain), .gain_select_o(gsel),
    .int_zero_mux_o(zmux), .int_full_mux_o(fmux), .filter_reset_o(frst)
  );
  acrc_host_model host (.sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));
  // Compare and report
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Wait for hready under a bound
  task hwait;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hro !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      test_done;
    end
  endtask
  // One single word transfer
  task ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hwait;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    r = hrdata;
    chk("response", 32'h0, hresp);
  endtask
  task wr(input logic [31:0] a, d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task rd(input logic [31:0] a, e, input string n);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask
  // One conversion from the modulator
  task pulse(input logic [23:0] v);
    @(posedge clk);
    rv  <= 1'b1;
    raw <= v;
    @(posedge clk);
    rv  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Expected calibration length in conversions
  function automatic int cal_len(int m, int g, int c);
    if (m == 5)
      return (g == 0) ? (c ? 2 : 1) : (c ? 4 : 2);
    return 2;
  endfunction
  // Expected corrected result
  function automatic logic [31:0] conv(logic [23:0] r, o, f);
    logic [47:0] p;
    p = (r - o) * f;
    return 32'(p >> 23);
  endfunction
  // One calibration run with checks
  task cal(input int m, g, c, ch);
    int n;
    logic [23:0] v;
    wr(32'h0, {21'h0, 3'(ch), 4'h0, 1'(c), 3'(g)});
    wr(32'h4, 32'(m));
    n = cal_len(m, g, c);
    repeat (2) @(posedge clk);
    chk("ready at start", 32'h1, rdy_n);
    chk("zero mux", 32'(m == 4), zmux);
    chk("full mux", 32'(m == 5), fmux);
    chk("gain", 32'(g), gsel);
    rd(32'h8, 32'h3, "status busy");
    repeat (n)
    begin
      chk("ready busy", 32'h1, rdy_n);
      v = 24'($random(seed));
      pulse(v);
    end
    chk("ready end", 32'h0, rdy_n);
    rd(32'h4, 32'h2, "mode idle");
    rd((m[0] ? 32'h20 : 32'h10) + 32'(4 * ch), {8'h0, v}, "coef");
  endtask
  // Main sequence
  initial
  begin
    logic [23:0] v;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (RW + 5) @(posedge clk);
    chk("ref after reset", 32'h1, {ref_int, ext_ref});
    chk("oe idle", 32'h1, oe_n);
    rd(32'h8, 32'h1, "status");
    rd(32'h0, 32'h8, "cfg");
    rd(32'h20, 32'h800000, "fs slot");
    rd(32'h40, 32'h0, "unmapped");
    wr(32'h0, 32'h10);
    repeat (2) @(posedge clk);
    chk("ref internal", 32'h2, {ref_int, ext_ref});
    wr(32'h0, 32'h700);
    repeat (2) @(posedge clk);
    chk("monitor", 32'hF, {sup_mon, ref_int, 2'(ain[2:1])});
    wr(32'h0, 32'h0);
    repeat (2) @(posedge clk);
    chk("ref external", 32'h1, {sup_mon, ref_int, ext_ref});
    // Zero before full, all modes, gain 128 kept out of internal full
    for (int r = 0; r < 4; r++)
      for (int m = 4; m < 8; m++)
        cal(m, r < 2 ? 0 : 1 + {$random(seed)} % 6, ~r & 1, {$random(seed)} % 3);
    wr(32'h0, 32'h0);
    wr(32'h10, 32'h1234);
    wr(32'h20, 32'h400000);
    for (int k = 0; k < 4; k++)
    begin
      wr(32'h4, 32'(k % 2));
      v = 24'h1234 + 24'({$random(seed)} % 32'h300000);
      pulse(v);
      chk("conv ready", 32'h0, rdy_n);
      rd(32'hC, conv(v, 24'h1234, 24'h400000), "data");
    end
    wr(32'h4, 32'h3);
    pulse(24'h5A5A5A);
    chk("pdown ignores", 32'h1, rdy_n);
    wr(32'h0, 32'h15);
    host.frame(31, 1'b1);
    repeat (40) @(posedge clk);
    chk("no reset", 32'h0, nfr);
    rd(32'h0, 32'h15, "cfg kept");
    host.frame(32, 1'b0);
    repeat (40) @(posedge clk);
    chk("filter reset", 32'h1, nfr);
    chk("oe selected", 32'h1, 32'(nsel > 0));
    chk("oe released", 32'h1, oe_n);
    repeat (RW + 5) @(posedge clk);
    rd(32'h0, 32'h8, "cfg default");
    rd(32'h20, 32'h800000, "fs default");
    test_done;
  end
  // Hang guard
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
